/* shared/kbm_cfg.svh */
// register indices, field positions, reset values and rates of the input controller config
`ifndef KBM_CFG_SVH
`define KBM_CFG_SVH
// register indices
`define IDX_ACT        8'h30
`define IDX_DATA_HI    8'h60
`define IDX_DATA_LO    8'h61
`define IDX_CMD_HI     8'h62
`define IDX_CMD_LO     8'h63
`define IDX_IRQ_NUM    8'h70
`define IDX_IRQ_TYPE   8'h71
`define IDX_NODMA_A    8'h74
`define IDX_NODMA_B    8'h75
`define IDX_CTRL_CFG   8'hf0
// field positions
`define ACT_BIT        0
`define CFG_CLK_MSB    7
`define CFG_CLK_LSB    6
`define CFG_SWAP_BIT   3
`define CFG_FLOAT_BIT  0
// reset values
`define RST_MOUSE_ACT  1'b0
`define RST_KBD_ACT    1'b1
`define RST_DATA_HI    3'h0
`define RST_DATA_LO    5'h0c
`define RST_CMD_HI     3'h0
`define RST_CMD_LO     5'h0c
`define CMD_LO_FIXED   3'h4
`define RST_MOUSE_IRQ  8'h0c
`define RST_KBD_IRQ    8'h01
`define RST_IRQ_TYPE   2'h2
`define NODMA_VAL      8'h04
`define RST_CLK_SEL    2'h1
`define RST_CFG        8'h40
// clock rates in MHz
`define SYS_CLK_MHZ    5'd20
`define RATE_8_MHZ     5'd8
`define RATE_12_MHZ    5'd12
`define RATE_16_MHZ    5'd16
`endif

/* shared/kbm_pkg.sv */
// types of the input controller configuration bank
package kbm_pkg;
  typedef enum logic [1:0] {CLK_8, CLK_12, CLK_16, CLK_RSVD} ctrlClkSel_t;
  typedef enum logic {BANK_MOUSE, BANK_KBD} bank_t;
  typedef struct packed {
    logic        mouseAct;
    logic        kbdAct;
    logic [2:0]  dataHi;
    logic [4:0]  dataLo;
    logic [2:0]  cmdHi;
    logic [4:0]  cmdLo;
    logic [7:0]  mouseIrqNum;
    logic [7:0]  kbdIrqNum;
    logic [1:0]  mouseIrqType;
    logic [1:0]  kbdIrqType;
    ctrlClkSel_t clkSel;
    logic        swap;
    logic        floatIdle;
    logic [7:0]  rdata;
    logic        kbdIrq;
    logic        mouseIrq;
    logic        untouched;
  } regState_t;
  typedef struct packed {
    logic [4:0] acc;
    logic       tick;
  } rateState_t;
  typedef struct packed {
    logic kbdClkOeN;
    logic kbdDatOeN;
    logic auxClkOeN;
    logic auxDatOeN;
    logic kbdClkIn;
    logic kbdDatIn;
    logic mouseClkIn;
    logic mouseDatIn;
  } pinState_t;
endpackage

/* shared/pin_route_if.sv */
// channel-to-pin routing signals between config bank and pin router
`timescale 1ns/1ns
interface pin_route_if;
  logic kbdClkLow;
  logic kbdDatLow;
  logic mouseClkLow;
  logic mouseDatLow;
  logic kbdClkIn;
  logic kbdDatIn;
  logic mouseClkIn;
  logic mouseDatIn;
  logic swap;
  logic floatKbdPins;
  logic floatAuxPins;
  modport cfg (
    output kbdClkLow, kbdDatLow, mouseClkLow, mouseDatLow,
    output swap, floatKbdPins, floatAuxPins,
    input  kbdClkIn, kbdDatIn, mouseClkIn, mouseDatIn
  );
  modport route (
    input  kbdClkLow, kbdDatLow, mouseClkLow, mouseDatLow,
    input  swap, floatKbdPins, floatAuxPins,
    output kbdClkIn, kbdDatIn, mouseClkIn, mouseDatIn
  );
endinterface

/* logic/clk_rate_gen.sv */
// controller clock-rate enable from the 20 MHz system clock
`timescale 1ns/1ns
`include "kbm_cfg.svh"
module clk_rate_gen (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // rate select and enable out
  input  wire kbm_pkg::ctrlClkSel_t sel,
  output logic                     tick
);
  import kbm_pkg::*;

  rateState_t state_ff;
  rateState_t nxt_state;
  logic [4:0] step;
  logic [5:0] sum;

  // ----------------------------------------
  // fractional accumulator
  // ----------------------------------------
  // rate per select
  always_comb begin
    case (sel)
      CLK_8:   step = `RATE_8_MHZ;
      CLK_12:  step = `RATE_12_MHZ;
      CLK_16:  step = `RATE_16_MHZ;
      default: step = 5'h00;
    endcase
    sum = {1'b0, state_ff.acc} + {1'b0, step};
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (sum >= {1'b0, `SYS_CLK_MHZ}) begin
      nxt_state.acc  = 5'(sum - {1'b0, `SYS_CLK_MHZ});
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.acc = sum[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] winCnt_ff;
  logic [4:0] tickCnt_ff;
  logic       selSame_ff;
  ctrlClkSel_t selLast_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      winCnt_ff  <= 5'h00;
      tickCnt_ff <= 5'h00;
      selSame_ff <= 1'b0;
      selLast_ff <= CLK_8;
    end else begin
      selLast_ff <= sel;
      if (winCnt_ff == 5'h13) begin
        winCnt_ff  <= 5'h00;
        tickCnt_ff <= {4'h0, nxt_state.tick};
        selSame_ff <= 1'b1;
      end else begin
        winCnt_ff  <= winCnt_ff + 5'h01;
        tickCnt_ff <= tickCnt_ff + {4'h0, nxt_state.tick};
        selSame_ff <= selSame_ff & (sel == selLast_ff);
      end
    end
  end

  property p_rate_window;
    @(posedge clk) disable iff (!rst_n)
      (winCnt_ff == 5'h13 && selSame_ff && sel == selLast_ff) |-> tickCnt_ff == step;
  endproperty
  a_rate_window: assert property (p_rate_window) else $error("rate ticks off");

  property p_rsvd_quiet;
    @(posedge clk) disable iff (!rst_n)
      (sel == CLK_RSVD) [*2] |-> !tick;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("tick on reserved");
endmodule

/* logic/pin_swap.sv */
// routes keyboard and mouse channels onto the two open-drain pin pairs
`timescale 1ns/1ns
module pin_swap (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // channel side
  pin_route_if.route rt,
  // keyboard pin pair
  input  wire logic  kbdClkPinIn,
  output logic       kbdClkPinOeN,
  input  wire logic  kbdDatPinIn,
  output logic       kbdDatPinOeN,
  // auxiliary pin pair
  input  wire logic  auxClkPinIn,
  output logic       auxClkPinOeN,
  input  wire logic  auxDatPinIn,
  output logic       auxDatPinOeN
);
  import kbm_pkg::*;

  pinState_t state_ff;
  pinState_t nxt_state;

  // ----------------------------------------
  // routing
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (rt.swap) begin
      nxt_state.kbdClkOeN  = ~rt.mouseClkLow;
      nxt_state.kbdDatOeN  = ~rt.mouseDatLow;
      nxt_state.auxClkOeN  = ~rt.kbdClkLow;
      nxt_state.auxDatOeN  = ~rt.kbdDatLow;
      nxt_state.kbdClkIn   = auxClkPinIn;
      nxt_state.kbdDatIn   = auxDatPinIn;
      nxt_state.mouseClkIn = kbdClkPinIn;
      nxt_state.mouseDatIn = kbdDatPinIn;
    end else begin
      nxt_state.kbdClkOeN  = ~rt.kbdClkLow;
      nxt_state.kbdDatOeN  = ~rt.kbdDatLow;
      nxt_state.auxClkOeN  = ~rt.mouseClkLow;
      nxt_state.auxDatOeN  = ~rt.mouseDatLow;
      nxt_state.kbdClkIn   = kbdClkPinIn;
      nxt_state.kbdDatIn   = kbdDatPinIn;
      nxt_state.mouseClkIn = auxClkPinIn;
      nxt_state.mouseDatIn = auxDatPinIn;
    end
    if (rt.floatKbdPins) begin
      nxt_state.kbdClkOeN = 1'b1;
      nxt_state.kbdDatOeN = 1'b1;
    end
    if (rt.floatAuxPins) begin
      nxt_state.auxClkOeN = 1'b1;
      nxt_state.auxDatOeN = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign kbdClkPinOeN  = state_ff.kbdClkOeN;
  assign kbdDatPinOeN  = state_ff.kbdDatOeN;
  assign auxClkPinOeN  = state_ff.auxClkOeN;
  assign auxDatPinOeN  = state_ff.auxDatOeN;
  assign rt.kbdClkIn   = state_ff.kbdClkIn;
  assign rt.kbdDatIn   = state_ff.kbdDatIn;
  assign rt.mouseClkIn = state_ff.mouseClkIn;
  assign rt.mouseDatIn = state_ff.mouseDatIn;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_swap_route;
    @(posedge clk) disable iff (!rst_n)
      (rt.swap && !rt.floatKbdPins && !rt.floatAuxPins)
        |=> (kbdClkPinOeN == !$past(rt.mouseClkLow)) && (auxDatPinOeN == !$past(rt.kbdDatLow));
  endproperty
  a_swap_route: assert property (p_swap_route) else $error("pin swap wrong");

  property p_float_kbd;
    @(posedge clk) disable iff (!rst_n)
      rt.floatKbdPins |=> kbdClkPinOeN && kbdDatPinOeN;
  endproperty
  a_float_kbd: assert property (p_float_kbd) else $error("keyboard pins driven");

  property p_float_aux;
    @(posedge clk) disable iff (!rst_n)
      rt.floatAuxPins |=> auxClkPinOeN && auxDatPinOeN;
  endproperty
  a_float_aux: assert property (p_float_aux) else $error("aux pins driven");
endmodule

/* logic/keyboard_mouse_config.sv */
// configuration bank of the embedded input controller: keyboard and mouse devices
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "kbm_cfg.svh"
module keyboard_mouse_config (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // register port
  input  wire logic [7:0]     regAddr,
  input  wire kbm_pkg::bank_t regBank,
  input  wire logic [7:0]     regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic [7:0]          regRdata,
  // global qualifier
  input  wire logic           globalEnable,
  // controller channel side
  input  wire logic           kbdClkLow,
  input  wire logic           kbdDatLow,
  input  wire logic           mouseClkLow,
  input  wire logic           mouseDatLow,
  output logic                kbdClkIn,
  output logic                kbdDatIn,
  output logic                mouseClkIn,
  output logic                mouseDatIn,
  output logic                ctrlClkEn,
  // interrupt requests and routing
  input  wire logic           kbdIrqReq,
  input  wire logic           mouseIrqReq,
  output logic                kbdIrq,
  output logic                mouseIrq,
  output logic [7:0]          kbdIrqNum,
  output logic [7:0]          mouseIrqNum,
  output logic [1:0]          kbdIrqType,
  output logic [1:0]          mouseIrqType,
  // decoded host addresses
  output logic [15:0]         kbdDataBase,
  output logic [15:0]         kbdCmdBase,
  // keyboard pin pair
  input  wire logic           kbdClkPinIn,
  output logic                kbdClkPinOut,
  output logic                kbdClkPinOeN,
  input  wire logic           kbdDatPinIn,
  output logic                kbdDatPinOut,
  output logic                kbdDatPinOeN,
  // auxiliary pin pair
  input  wire logic           auxClkPinIn,
  output logic                auxClkPinOut,
  output logic                auxClkPinOeN,
  input  wire logic           auxDatPinIn,
  output logic                auxDatPinOut,
  output logic                auxDatPinOeN
);
  import kbm_pkg::*;

  regState_t   state_ff;
  regState_t   nxt_state;
  logic [7:0]  rdVal;
  logic [7:0]  cfgByte;
  logic        mouseLive;
  logic        kbdLive;
  pin_route_if rt ();

  // ----------------------------------------
  // device activity
  // ----------------------------------------
  // global qualifier
  assign mouseLive = state_ff.mouseAct & globalEnable;
  assign kbdLive   = state_ff.kbdAct & globalEnable;

  assign cfgByte = {state_ff.clkSel, 2'b00, state_ff.swap, 2'b00, state_ff.floatIdle};

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rdVal = 8'h00;
    if (regBank == BANK_MOUSE) begin
      case (regAddr)
        `IDX_ACT:      rdVal = {7'h00, state_ff.mouseAct};
        `IDX_IRQ_NUM:  rdVal = state_ff.mouseIrqNum;
        `IDX_IRQ_TYPE: rdVal = {6'h00, state_ff.mouseIrqType};
        `IDX_NODMA_A:  rdVal = `NODMA_VAL;
        `IDX_NODMA_B:  rdVal = `NODMA_VAL;
        default:       rdVal = 8'h00;
      endcase
    end else begin
      case (regAddr)
        `IDX_ACT:      rdVal = {7'h00, state_ff.kbdAct};
        `IDX_DATA_HI:  rdVal = {5'h00, state_ff.dataHi};
        `IDX_DATA_LO:  rdVal = {state_ff.dataLo, 3'h0};
        `IDX_CMD_HI:   rdVal = {5'h00, state_ff.cmdHi};
        `IDX_CMD_LO:   rdVal = {state_ff.cmdLo, `CMD_LO_FIXED};
        `IDX_IRQ_NUM:  rdVal = state_ff.kbdIrqNum;
        `IDX_IRQ_TYPE: rdVal = {6'h00, state_ff.kbdIrqType};
        `IDX_NODMA_A:  rdVal = `NODMA_VAL;
        `IDX_NODMA_B:  rdVal = `NODMA_VAL;
        `IDX_CTRL_CFG: rdVal = cfgByte;
        default:       rdVal = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = 8'h00;
    if (regRd) begin
      nxt_state.rdata = rdVal;
    end
    if (regWr) begin
      nxt_state.untouched = 1'b0;
    end
    if (regWr && regBank == BANK_MOUSE) begin
      case (regAddr)
        `IDX_ACT:      nxt_state.mouseAct = regWdata[`ACT_BIT];
        `IDX_IRQ_NUM:  nxt_state.mouseIrqNum = regWdata;
        `IDX_IRQ_TYPE: nxt_state.mouseIrqType = regWdata[1:0];
        default:       nxt_state.mouseIrqType = state_ff.mouseIrqType;
      endcase
    end
    if (regWr && regBank == BANK_KBD) begin
      case (regAddr)
        `IDX_ACT:      nxt_state.kbdAct = regWdata[`ACT_BIT];
        `IDX_DATA_HI:  nxt_state.dataHi = regWdata[2:0];
        `IDX_DATA_LO:  nxt_state.dataLo = regWdata[7:3];
        `IDX_CMD_HI:   nxt_state.cmdHi = regWdata[2:0];
        `IDX_CMD_LO:   nxt_state.cmdLo = regWdata[7:3];
        `IDX_IRQ_NUM:  nxt_state.kbdIrqNum = regWdata;
        `IDX_IRQ_TYPE: nxt_state.kbdIrqType = regWdata[1:0];
        `IDX_CTRL_CFG: begin
          nxt_state.clkSel    = ctrlClkSel_t'(regWdata[`CFG_CLK_MSB:`CFG_CLK_LSB]);
          nxt_state.swap      = regWdata[`CFG_SWAP_BIT];
          nxt_state.floatIdle = regWdata[`CFG_FLOAT_BIT];
        end
        default:       nxt_state.kbdAct = state_ff.kbdAct;
      endcase
    end
    nxt_state.mouseIrq = mouseIrqReq & mouseLive;
    nxt_state.kbdIrq   = kbdIrqReq & kbdLive;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.mouseAct     <= `RST_MOUSE_ACT;
      state_ff.kbdAct       <= `RST_KBD_ACT;
      state_ff.dataHi       <= `RST_DATA_HI;
      state_ff.dataLo       <= `RST_DATA_LO;
      state_ff.cmdHi        <= `RST_CMD_HI;
      state_ff.cmdLo        <= `RST_CMD_LO;
      state_ff.mouseIrqNum  <= `RST_MOUSE_IRQ;
      state_ff.kbdIrqNum    <= `RST_KBD_IRQ;
      state_ff.mouseIrqType <= `RST_IRQ_TYPE;
      state_ff.kbdIrqType   <= `RST_IRQ_TYPE;
      state_ff.clkSel       <= CLK_12;
      state_ff.swap         <= 1'b0;
      state_ff.floatIdle    <= 1'b0;
      state_ff.rdata        <= 8'h00;
      state_ff.kbdIrq       <= 1'b0;
      state_ff.mouseIrq     <= 1'b0;
      state_ff.untouched    <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata     = state_ff.rdata;
  assign kbdIrq       = state_ff.kbdIrq;
  assign mouseIrq     = state_ff.mouseIrq;
  assign kbdIrqNum    = state_ff.kbdIrqNum;
  assign mouseIrqNum  = state_ff.mouseIrqNum;
  assign kbdIrqType   = state_ff.kbdIrqType;
  assign mouseIrqType = state_ff.mouseIrqType;
  assign kbdDataBase  = {5'h00, state_ff.dataHi, state_ff.dataLo, 3'h0};
  assign kbdCmdBase   = {5'h00, state_ff.cmdHi, state_ff.cmdLo, `CMD_LO_FIXED};
  assign kbdClkPinOut = 1'b0;
  assign kbdDatPinOut = 1'b0;
  assign auxClkPinOut = 1'b0;
  assign auxDatPinOut = 1'b0;

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  // channel lows not gated; aux pins float when floatIdle is set and the mouse is not live
  assign rt.mouseClkLow  = mouseClkLow;
  assign rt.mouseDatLow  = mouseDatLow;
  assign rt.kbdClkLow    = kbdClkLow;
  assign rt.kbdDatLow    = kbdDatLow;
  assign rt.swap         = state_ff.swap;
  assign rt.floatKbdPins = state_ff.floatIdle & ~kbdLive;
  assign rt.floatAuxPins = state_ff.floatIdle & ~mouseLive;
  assign kbdClkIn        = rt.kbdClkIn;
  assign kbdDatIn        = rt.kbdDatIn;
  assign mouseClkIn      = rt.mouseClkIn;
  assign mouseDatIn      = rt.mouseDatIn;

  pin_swap u_pins (
    .clk          (clk),
    .rst_n        (rst_n),
    .rt           (rt.route),
    .kbdClkPinIn  (kbdClkPinIn),
    .kbdClkPinOeN (kbdClkPinOeN),
    .kbdDatPinIn  (kbdDatPinIn),
    .kbdDatPinOeN (kbdDatPinOeN),
    .auxClkPinIn  (auxClkPinIn),
    .auxClkPinOeN (auxClkPinOeN),
    .auxDatPinIn  (auxDatPinIn),
    .auxDatPinOeN (auxDatPinOeN)
  );

  // ----------------------------------------
  // controller clock rate
  // ----------------------------------------
  clk_rate_gen u_rate (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (state_ff.clkSel),
    .tick  (ctrlClkEn)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rd_mouse(logic [7:0] idx);
    regRd && regBank == BANK_MOUSE && regAddr == idx;
  endsequence

  sequence s_rd_kbd(logic [7:0] idx);
    regRd && regBank == BANK_KBD && regAddr == idx;
  endsequence

  property p_mouse_irq_off;
    @(posedge clk) disable iff (!rst_n)
      !mouseLive |=> !mouseIrq;
  endproperty
  a_mouse_irq_off: assert property (p_mouse_irq_off) else $error("mouse irq while idle");

  property p_kbd_irq_gate;
    @(posedge clk) disable iff (!rst_n)
      kbdIrqReq && kbdLive |=> kbdIrq;
  endproperty
  a_kbd_irq_gate: assert property (p_kbd_irq_gate) else $error("keyboard irq lost");

  property p_mouse_num_rst;
    @(posedge clk) disable iff (!rst_n)
      s_rd_mouse(`IDX_IRQ_NUM) ##0 state_ff.untouched |=> regRdata == `RST_MOUSE_IRQ;
  endproperty
  a_mouse_num_rst: assert property (p_mouse_num_rst) else $error("mouse irq num reset");

  property p_kbd_num_rst;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_IRQ_NUM) ##0 state_ff.untouched |=> regRdata == `RST_KBD_IRQ;
  endproperty
  a_kbd_num_rst: assert property (p_kbd_num_rst) else $error("kbd irq num reset");

  property p_cfg_rst;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_CTRL_CFG) ##0 state_ff.untouched |=> regRdata == `RST_CFG;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("config reset value");

  property p_type_fixed;
    @(posedge clk) disable iff (!rst_n)
      regRd && regAddr == `IDX_IRQ_TYPE |=> regRdata[7:2] == 6'h00;
  endproperty
  a_type_fixed: assert property (p_type_fixed) else $error("type fixed bits");

  property p_no_dma;
    @(posedge clk) disable iff (!rst_n)
      regRd && (regAddr == `IDX_NODMA_A || regAddr == `IDX_NODMA_B) |=> regRdata == `NODMA_VAL;
  endproperty
  a_no_dma: assert property (p_no_dma) else $error("no dma value");

  property p_data_lo;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_DATA_LO) |=> regRdata[2:0] == 3'h0;
  endproperty
  a_data_lo: assert property (p_data_lo) else $error("data base low bits");

  property p_cmd_lo;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_CMD_LO) |=> regRdata[2:0] == `CMD_LO_FIXED;
  endproperty
  a_cmd_lo: assert property (p_cmd_lo) else $error("command base low bits");

  property p_cfg_rsvd;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_CTRL_CFG) |=> regRdata[5:4] == 2'b00 && regRdata[2:1] == 2'b00;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved cfg bits");

  property p_float_kbd_top;
    @(posedge clk) disable iff (!rst_n)
      state_ff.floatIdle && !kbdLive |=> kbdClkPinOeN && kbdDatPinOeN;
  endproperty
  a_float_kbd_top: assert property (p_float_kbd_top) else $error("kbd pins not floated");

  property p_mouse_route;
    @(posedge clk) disable iff (!rst_n)
      !rt.swap && !rt.floatAuxPins |=> auxDatPinOeN == !$past(mouseDatLow);
  endproperty
  a_mouse_route: assert property (p_mouse_route) else $error("mouse pins gated");

  property p_kbd_act_rst;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_ACT) ##0 state_ff.untouched |=> regRdata == {7'h00, `RST_KBD_ACT};
  endproperty
  a_kbd_act_rst: assert property (p_kbd_act_rst) else $error("kbd activate reset");

  property p_kbd_type_rst;
    @(posedge clk) disable iff (!rst_n)
      s_rd_kbd(`IDX_IRQ_TYPE) ##0 state_ff.untouched |=> regRdata == {6'h00, `RST_IRQ_TYPE};
  endproperty
  a_kbd_type_rst: assert property (p_kbd_type_rst) else $error("kbd irq type reset");
endmodule

/* bench/kbm_peer_model.sv */
// open-drain keyboard and pointing peers on both pin pairs
`timescale 1ns/1ns
module kbm_peer_model (
  // controller enables, low = pull low
  input  wire logic [3:0] hostOeN,
  // peer pulls, high = pull low
  input  wire logic [3:0] peerLow,
  // resolved wire levels
  output logic      [3:0] pinLvl
);
  // ---------
  // wired-and
  // ---------
  // released lines rise through the pull-up
  assign pinLvl = hostOeN & ~peerLow;
endmodule

/* bench/keyboard_mouse_config_tb_top.sv */
// register-level bench of the keyboard and mouse configuration bank
`timescale 1ns/1ns
module keyboard_mouse_config_tb_top;
  import kbm_pkg::*;
  // -------
  // signals
  // -------
  logic        clk, rst_n, regWr, regRd, globalEnable, ctrlClkEn;
  logic        kbdClkLow, kbdDatLow, mouseClkLow, mouseDatLow, kbdIrqReq, mouseIrqReq;
  logic        kbdClkIn, kbdDatIn, mouseClkIn, mouseDatIn, kbdIrq, mouseIrq;
  logic [7:0]  regAddr, regWdata, regRdata, kbdIrqNum, mouseIrqNum;
  logic [1:0]  kbdIrqType, mouseIrqType;
  logic [15:0] kbdDataBase, kbdCmdBase, n;
  logic [3:0]  oeN, outs, peerLow, lvl;
  bank_t       regBank;
  int          miscompares, tests_run;
  logic [19:0] rstTab [17] = '{20'h03000, 20'h0700c, 20'h07102, 20'h07404, 20'h07504,
    20'h0f000, 20'h13001, 20'h16000, 20'h16160, 20'h16200, 20'h16364, 20'h17001,
    20'h17102, 20'h17404, 20'h17504, 20'h1f040, 20'h18000};
  logic [27:0] wrTab [9] = '{28'h160ff07, 28'h161fff8, 28'h16300_04, 28'h162ff07,
    28'h171ff03, 28'h071fd01, 28'h17400_04, 28'h075ff04, 28'h0705a5a};
  logic [15:0] rateExp [4] = '{16'h0008, 16'h000c, 16'h0010, 16'h0000};
  // ---------
  // instances
  // ---------
  keyboard_mouse_config i_keyboard_mouse_config (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regBank(regBank), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .globalEnable(globalEnable),
    .kbdClkLow(kbdClkLow), .kbdDatLow(kbdDatLow), .mouseClkLow(mouseClkLow),
    .mouseDatLow(mouseDatLow), .kbdClkIn(kbdClkIn), .kbdDatIn(kbdDatIn),
    .mouseClkIn(mouseClkIn), .mouseDatIn(mouseDatIn), .ctrlClkEn(ctrlClkEn),
    .kbdIrqReq(kbdIrqReq), .mouseIrqReq(mouseIrqReq), .kbdIrq(kbdIrq),
    .mouseIrq(mouseIrq), .kbdIrqNum(kbdIrqNum), .mouseIrqNum(mouseIrqNum),
    .kbdIrqType(kbdIrqType), .mouseIrqType(mouseIrqType), .kbdDataBase(kbdDataBase),
    .kbdCmdBase(kbdCmdBase), .kbdClkPinIn(lvl[3]), .kbdClkPinOut(outs[3]),
    .kbdClkPinOeN(oeN[3]), .kbdDatPinIn(lvl[2]), .kbdDatPinOut(outs[2]),
    .kbdDatPinOeN(oeN[2]), .auxClkPinIn(lvl[1]), .auxClkPinOut(outs[1]),
    .auxClkPinOeN(oeN[1]), .auxDatPinIn(lvl[0]), .auxDatPinOut(outs[0]),
    .auxDatPinOeN(oeN[0]));
  kbm_peer_model i_kbm_peer_model (.hostOeN(oeN), .peerLow(peerLow), .pinLvl(lvl));
  // -----
  // tasks
  // -----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bank_t b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regBank <= b;
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input bank_t b, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regBank <= b;
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk({8'h00, regRdata}, {8'h00, e});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // --------
  // sequence
  // --------
  always #25 clk = ~clk;
  initial begin
    #(50 * 3000);
    miscompares++;
    test_done();
  end
  initial begin
    {clk, rst_n, regWr, regRd, regAddr, regWdata, peerLow} = '0;
    {kbdClkLow, kbdDatLow, mouseClkLow, mouseDatLow} = '0;
    {globalEnable, kbdIrqReq, mouseIrqReq} = 3'h7;
    regBank = BANK_KBD;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rstTab[i]) rd(bank_t'(rstTab[i][16]), rstTab[i][15:8], rstTab[i][7:0]);
    chk({kbdIrq, mouseIrq}, 16'h0002);
    @(posedge clk);
    kbdClkLow <= 1'b1;
    peerLow <= 4'b0100;
    settle();
    chk({outs, oeN, kbdClkIn, kbdDatIn, mouseClkIn, mouseDatIn}, 16'h0073);
    wr(BANK_KBD, 8'h30, 8'h00);
    settle();
    chk({kbdIrq, mouseIrq}, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(BANK_KBD, 8'hf0, {s[1:0], 6'h00});
      repeat (4) @(posedge clk);
      n = '0;
      repeat (20) begin
        @(negedge clk);
        n = n + {15'h0000, ctrlClkEn};
      end
      chk(n, rateExp[s]);
    end
    wr(BANK_KBD, 8'hf0, 8'hff);
    rd(BANK_KBD, 8'hf0, 8'hc9);
    foreach (wrTab[i]) begin
      wr(bank_t'(wrTab[i][24]), wrTab[i][23:16], wrTab[i][15:8]);
      rd(bank_t'(wrTab[i][24]), wrTab[i][23:16], wrTab[i][7:0]);
    end
    chk(kbdDataBase, 16'h07f8);
    chk(kbdCmdBase, 16'h0704);
    chk({kbdIrqType, mouseIrqType, mouseIrqNum}, 16'h0d5a);
    chk({8'h00, kbdIrqNum}, 16'h0001);
    wr(BANK_KBD, 8'hf0, 8'h08);
    peerLow <= 4'b0001;
    settle();
    chk({oeN, kbdClkIn, kbdDatIn, mouseClkIn, mouseDatIn}, 16'h00d3);
    wr(BANK_KBD, 8'hf0, 8'h01);
    mouseDatLow <= 1'b1;
    settle();
    chk({12'h000, oeN}, 16'h000f);
    wr(BANK_MOUSE, 8'h30, 8'h01);
    settle();
    chk({oeN, mouseIrq}, 16'h001d);
    @(posedge clk);
    globalEnable <= 1'b0;
    settle();
    chk({oeN, mouseIrq}, 16'h001e);
    test_done();
  end
endmodule
